// ### verilog/spg_top.sv
// Serial port, general-purpose lines, LEDs and mode selection
`timescale 1ns/1ps
module spg_top #(
  parameter int unsigned BLANK_CYC = spg_pkg::BLANK_CYCLES
) (
  // Clock, reset, enable
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Serial configuration
  input wire logic [15:0] BAUD_DIV_I,
  input wire logic [2:0] PARITY_MODE_I,
  input wire logic CHAR_8BIT_I,
  // Line functions
  input wire logic GP_B_DSR_EN_I,
  input wire logic GP_C_DTR_EN_I,
  input wire logic [1:0] GP_D_MODE_I,
  input wire logic GP_E_RTS_EN_I,
  input wire logic [3:0] GP_OUT_I,
  output logic [3:0] GP_IN_O,
  input wire logic DTR_ASSERT_I,
  output logic DSR_ACTIVE_O,
  output logic HALF_DUPLEX_O,
  // Transmit stream
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  // Receive stream
  input wire logic RX_ACCEPT_I,
  output logic [7:0] RX_DATA_O,
  output logic RX_VALID_O,
  output logic RX_PARITY_ERR_O,
  output logic RX_FRAME_ERR_O,
  // Serial pins
  output logic TX_O,
  input wire logic RX_I,
  // General-purpose pins b to e
  input wire logic GP_B_I,
  output logic GP_B_O,
  output logic GP_B_OE_O,
  input wire logic GP_C_I,
  output logic GP_C_O,
  output logic GP_C_OE_O,
  input wire logic GP_D_I,
  output logic GP_D_O,
  output logic GP_D_OE_O,
  input wire logic GP_E_I,
  output logic GP_E_O,
  output logic GP_E_OE_O,
  // Link and status LEDs
  input wire logic LINK_UP_I,
  input wire logic LINK_100M_I,
  input wire logic PKT_RX_I,
  input wire logic STATUS_GREEN_I,
  input wire logic STATUS_RED_I,
  output logic LINK_SPEED_LED_O,
  output logic LINK_ACT_LED_O,
  output logic STATUS_LED_A_O,
  output logic STATUS_LED_B_O,
  // Mode selection
  input wire logic BOOT_MODE_SELECT_I,
  output logic APP_RUN_O,
  output logic UPGRADE_MODE_O,
  output logic PROG_MODE_O
);
  import spg_pkg::*;

  spg_tx_e tx_st_q;
  spg_rx_e rx_st_q;
  spg_mode_e mode_st_q;
  logic [15:0] tx_cnt_q, rx_cnt_q;
  logic [3:0] tx_idx_q, rx_idx_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic tx_q, tx_par_q, rx_par_q;
  logic [31:0] blank_q;
  logic [3:0] latch, level;
  logic half, cts_ok, tx_acc, tx_tick, rx_tick, par_on, mode_prev_q;
  logic [3:0] nbits;

  function automatic logic par_calc(input logic [7:0] d, input logic b8, input logic [2:0] m);
    logic x;
    x = b8 ? ^d : ^d[6:0];
    case (m)
      PAR_EVEN: par_calc = x;
      PAR_ODD: par_calc = ~x;
      PAR_MARK: par_calc = 1'b1;
      default: par_calc = 1'b0;
    endcase
  endfunction

  // Line functions
  assign half = (GP_D_MODE_I == GPD_DUPLEX) && level[2];
  assign cts_ok = (GP_D_MODE_I != GPD_CTS) || !level[2];
  always_comb begin
    latch[0] = GP_B_DSR_EN_I ? 1'b1 : GP_OUT_I[0];
    latch[1] = GP_C_DTR_EN_I ? ~DTR_ASSERT_I : GP_OUT_I[1];
    latch[2] = (GP_D_MODE_I != GPD_GPIO) ? 1'b1 : GP_OUT_I[2];
    if (GP_E_RTS_EN_I) begin
      latch[3] = half ? (tx_st_q != TX_IDLE) : ~RX_ACCEPT_I;
    end else begin
      latch[3] = GP_OUT_I[3];
    end
  end

  spg_qb_line u_gp_b (.clk_i(MCLK_I), .rst_n_i(NRST_I), .ce_i(CE_I), .latch_i(latch[0]),
    .pin_i(GP_B_I), .pin_o(GP_B_O), .pin_oe_o(GP_B_OE_O), .level_o(level[0]));
  spg_qb_line u_gp_c (.clk_i(MCLK_I), .rst_n_i(NRST_I), .ce_i(CE_I), .latch_i(latch[1]),
    .pin_i(GP_C_I), .pin_o(GP_C_O), .pin_oe_o(GP_C_OE_O), .level_o(level[1]));
  spg_qb_line u_gp_d (.clk_i(MCLK_I), .rst_n_i(NRST_I), .ce_i(CE_I), .latch_i(latch[2]),
    .pin_i(GP_D_I), .pin_o(GP_D_O), .pin_oe_o(GP_D_OE_O), .level_o(level[2]));
  spg_qb_line u_gp_e (.clk_i(MCLK_I), .rst_n_i(NRST_I), .ce_i(CE_I), .latch_i(latch[3]),
    .pin_i(GP_E_I), .pin_o(GP_E_O), .pin_oe_o(GP_E_OE_O), .level_o(level[3]));

  assign GP_IN_O = level;
  assign DSR_ACTIVE_O = GP_B_DSR_EN_I && !level[0];
  assign HALF_DUPLEX_O = half;

  // Transmitter
  assign nbits = CHAR_8BIT_I ? BIT_CNT_8 : BIT_CNT_7;
  assign par_on = (PARITY_MODE_I != PAR_NONE);
  assign TX_READY_O = (tx_st_q == TX_IDLE) && cts_ok;
  assign tx_acc = TX_VALID_I && TX_READY_O;
  assign tx_tick = (tx_cnt_q == 16'h0);
  assign TX_O = tx_q;

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_st_q <= TX_IDLE;
      tx_q <= IDLE_LEVEL;
      tx_cnt_q <= 16'h0;
      tx_idx_q <= 4'h0;
      tx_sh_q <= 8'h0;
      tx_par_q <= 1'b0;
    end else if (CE_I) begin
      tx_cnt_q <= tx_tick ? BAUD_DIV_I - 16'h1 : tx_cnt_q - 16'h1;
      case (tx_st_q)
        TX_IDLE: begin
          tx_q <= IDLE_LEVEL;
          if (tx_acc) begin
            tx_st_q <= TX_START;
            tx_q <= 1'b0;
            tx_cnt_q <= BAUD_DIV_I - 16'h1;
            tx_sh_q <= TX_DATA_I;
            tx_idx_q <= 4'h0;
            tx_par_q <= par_calc(TX_DATA_I, CHAR_8BIT_I, PARITY_MODE_I);
          end
        end
        TX_START, TX_DATA: begin
          if (tx_tick) begin
            if (tx_st_q == TX_DATA && tx_idx_q == nbits) begin
              tx_st_q <= par_on ? TX_PAR : TX_STOP;
              tx_q <= par_on ? tx_par_q : 1'b1;
            end else begin
              tx_st_q <= TX_DATA;
              tx_q <= tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_idx_q <= tx_idx_q + 4'h1;
            end
          end
        end
        TX_PAR: begin
          if (tx_tick) begin
            tx_st_q <= TX_STOP;
            tx_q <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Receiver, samples mid-bit
  assign rx_tick = (rx_cnt_q == 16'h0);
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 16'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 8'h0;
      rx_par_q <= 1'b0;
      RX_DATA_O <= 8'h0;
      RX_VALID_O <= 1'b0;
      RX_PARITY_ERR_O <= 1'b0;
      RX_FRAME_ERR_O <= 1'b0;
    end else if (CE_I) begin
      RX_VALID_O <= 1'b0;
      rx_cnt_q <= rx_tick ? BAUD_DIV_I - 16'h1 : rx_cnt_q - 16'h1;
      case (rx_st_q)
        RX_IDLE: begin
          if (!RX_I) begin
            rx_st_q <= RX_START;
            rx_cnt_q <= {1'b0, BAUD_DIV_I[15:1]};
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_st_q <= RX_I ? RX_IDLE : RX_DATA;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 8'h0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sh_q <= CHAR_8BIT_I ? {RX_I, rx_sh_q[7:1]} : {1'b0, RX_I, rx_sh_q[6:1]};
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q + 4'h1 == nbits) begin
              rx_st_q <= par_on ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_tick) begin
            rx_par_q <= RX_I;
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_st_q <= RX_IDLE;
            RX_DATA_O <= rx_sh_q;
            RX_VALID_O <= 1'b1;
            RX_FRAME_ERR_O <= !RX_I;
            RX_PARITY_ERR_O <= par_on &&
              (rx_par_q != par_calc(rx_sh_q, CHAR_8BIT_I, PARITY_MODE_I));
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // LEDs
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      LINK_SPEED_LED_O <= 1'b0;
      STATUS_LED_A_O <= 1'b0;
      STATUS_LED_B_O <= 1'b0;
    end else if (CE_I) begin
      LINK_SPEED_LED_O <= LINK_UP_I && LINK_100M_I;
      STATUS_LED_A_O <= STATUS_GREEN_I;
      STATUS_LED_B_O <= STATUS_RED_I;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      blank_q <= 32'h0;
      LINK_ACT_LED_O <= 1'b0;
    end else if (CE_I) begin
      if (PKT_RX_I) begin
        blank_q <= 32'(BLANK_CYC);
      end else if (blank_q != 32'h0) begin
        blank_q <= blank_q - 32'h1;
      end
      LINK_ACT_LED_O <= LINK_UP_I && !PKT_RX_I && (blank_q <= 32'h1);
    end
  end

  // Mode selection, sampled on first enabled edge after reset
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_st_q <= MODE_BOOT;
      mode_prev_q <= 1'b1;
    end else if (CE_I) begin
      mode_prev_q <= BOOT_MODE_SELECT_I;
      case (mode_st_q)
        MODE_BOOT: mode_st_q <= BOOT_MODE_SELECT_I ? MODE_APP : MODE_UPGRADE;
        MODE_APP: begin
          if (mode_prev_q && !BOOT_MODE_SELECT_I) begin
            mode_st_q <= MODE_PROG;
          end
        end
        MODE_UPGRADE, MODE_PROG: mode_st_q <= mode_st_q;
        default: mode_st_q <= MODE_BOOT;
      endcase
    end
  end

  assign APP_RUN_O = (mode_st_q == MODE_APP);
  assign UPGRADE_MODE_O = (mode_st_q == MODE_UPGRADE);
  assign PROG_MODE_O = (mode_st_q == MODE_PROG);

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  a_tx_idle_high: assert property (tx_st_q == TX_IDLE && $past(tx_st_q) == TX_IDLE
    |-> TX_O)
    else $error("tx line not high when idle");
  a_tx_start_low: assert property (tx_acc && CE_I |=> !TX_O && tx_st_q == TX_START)
    else $error("no low start bit");
  a_tx_stop_high: assert property (tx_st_q == TX_STOP |-> TX_O)
    else $error("stop bit not high");
  a_cts_blocks_tx: assert property (GP_D_MODE_I == GPD_CTS && $past(CE_I) && $past(GP_D_I)
    |-> !TX_READY_O)
    else $error("transmit taken while clear-to-send high");
  a_sense_release: assert property (GP_B_DSR_EN_I && CE_I |=> !GP_B_OE_O)
    else $error("sensing line still pulled low");
  a_dtr_drive: assert property (GP_C_DTR_EN_I && DTR_ASSERT_I && CE_I |=> GP_C_OE_O)
    else $error("terminal-ready line not pulled low");
  a_dir_follow: assert property (GP_E_RTS_EN_I && half && tx_st_q != TX_IDLE && CE_I
    |=> !GP_E_OE_O)
    else $error("direction line low during transmit");
  a_speed_led: assert property (CE_I |=>
    LINK_SPEED_LED_O == $past(LINK_UP_I && LINK_100M_I))
    else $error("speed led wrong");
  a_act_blank: assert property (PKT_RX_I && CE_I ##1 CE_I |=> !LINK_ACT_LED_O)
    else $error("activity led not blanked");
  a_boot_upgrade: assert property (mode_st_q == MODE_BOOT && CE_I && !BOOT_MODE_SELECT_I
    |=> UPGRADE_MODE_O [*2])
    else $error("low mode select did not enter upgrade");
  a_prog_entry: assert property (APP_RUN_O && mode_prev_q && !BOOT_MODE_SELECT_I && CE_I
    |=> PROG_MODE_O)
    else $error("programming mode not entered");

  c_tx_frame: cover property (tx_st_q == TX_PAR ##[1:1000] tx_st_q == TX_IDLE);
  c_rx_char: cover property (RX_VALID_O && !RX_FRAME_ERR_O);
  c_prog_mode: cover property (APP_RUN_O ##1 PROG_MODE_O);
endmodule

// ### verilog/spg_pkg.sv
// Package: constants for the serial port, general-purpose line and mode block
package spg_pkg;
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned MAX_BAUD_BPS = 115_200;
  localparam logic [15:0] DEF_BAUD_DIV = 16'(CLK_FREQ_HZ / MAX_BAUD_BPS);
  localparam int unsigned BLANK_TIME_MS = 20;
  localparam int unsigned BLANK_CYCLES = (CLK_FREQ_HZ / 1000) * BLANK_TIME_MS;
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  localparam logic [1:0] GPD_GPIO = 2'h0;
  localparam logic [1:0] GPD_CTS = 2'h1;
  localparam logic [1:0] GPD_DUPLEX = 2'h2;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic LATCH_RESET = 1'b1;
  localparam logic [3:0] BIT_CNT_7 = 4'h7;
  localparam logic [3:0] BIT_CNT_8 = 4'h8;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} spg_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spg_rx_e;
  typedef enum {MODE_BOOT, MODE_APP, MODE_UPGRADE, MODE_PROG} spg_mode_e;
endpackage

// ### verilog/spg_qb_line.sv
// Quasi-bidirectional general-purpose line with output latch
`timescale 1ns/1ps
module spg_qb_line (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Latch and pin
  input wire logic latch_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic level_o
);
  import spg_pkg::*;
  logic latch_q;
  logic level_q;

  // Latch low pulls the line; latch high releases to the pull-up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= LATCH_RESET;
    end else if (ce_i) begin
      latch_q <= latch_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_q <= IDLE_LEVEL;
    end else if (ce_i) begin
      level_q <= pin_i;
    end
  end

  assign pin_o = 1'b0;
  assign pin_oe_o = ~latch_q;
  assign level_o = level_q;
endmodule

// ### tb/spg_host_model.sv
// Host-side serial partner: sends and captures character frames
`timescale 1ns/1ps
module spg_host_model #(
  parameter int DIV = 8
) (
  input wire logic clk_i,
  input wire logic dev_tx_i,
  output logic dev_rx_o
);
  initial dev_rx_o = 1'b1;
  // Sends n bits from the start bit on, LSB first, then idles high
  task automatic put_frame(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      dev_rx_o = f[i];
      repeat (DIV - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    dev_rx_o = 1'b1;
  endtask
  // Captures n bits at bit centres from the falling start edge
  task automatic get_frame(input int n, output logic [10:0] f, output bit ok);
    int t;
    t = 0;
    f = 11'h0;
    while (dev_tx_i === 1'b1 && t < 4000) begin
      @(negedge clk_i);
      t++;
    end
    ok = (t < 4000);
    repeat (DIV / 2) @(negedge clk_i);
    f[0] = dev_tx_i;
    for (int i = 1; i < n; i++) begin
      repeat (DIV) @(negedge clk_i);
      f[i] = dev_tx_i;
    end
  endtask
endmodule

// ### tb/spg_top_bench.sv
// Bench for the serial port, general-purpose line and mode block
`timescale 1ns/1ps
module spg_top_bench;
  import spg_pkg::*;
  localparam int DIV = 8;
  logic MCLK_I = 1'b0, NRST_I = 1'b0, CE_I = 1'b1, CHAR_8BIT_I = 1'b0;
  logic GP_B_DSR_EN_I = 1'b0, GP_C_DTR_EN_I = 1'b0, GP_E_RTS_EN_I = 1'b0;
  logic DTR_ASSERT_I = 1'b0, TX_VALID_I = 1'b0, RX_ACCEPT_I = 1'b0, LINK_UP_I = 1'b0;
  logic LINK_100M_I = 1'b0, PKT_RX_I = 1'b0, STATUS_GREEN_I = 1'b0, STATUS_RED_I = 1'b0;
  logic BOOT_MODE_SELECT_I = 1'b1;
  logic [15:0] BAUD_DIV_I = 16'(DIV);
  logic [2:0] PARITY_MODE_I = 3'h0;
  logic [1:0] GP_D_MODE_I = 2'h0;
  logic [3:0] GP_OUT_I = 4'hF, ext = 4'h0, GP_IN_O;
  logic [7:0] TX_DATA_I = 8'h0, RX_DATA_O;
  logic DSR_ACTIVE_O, HALF_DUPLEX_O, TX_READY_O, RX_VALID_O, RX_PARITY_ERR_O, RX_FRAME_ERR_O;
  logic TX_O, RX_I, LINK_SPEED_LED_O, LINK_ACT_LED_O, STATUS_LED_A_O, STATUS_LED_B_O;
  logic APP_RUN_O, UPGRADE_MODE_O, PROG_MODE_O, GP_B_I, GP_B_O, GP_B_OE_O, GP_C_I, GP_C_O;
  logic GP_C_OE_O, GP_D_I, GP_D_O, GP_D_OE_O, GP_E_I, GP_E_O, GP_E_OE_O;
  int n_fail = 0;
  int checks_done = 0;
  // Pins float high, low when either side pulls
  assign GP_B_I = ~GP_B_OE_O & ~ext[0];
  assign GP_C_I = ~GP_C_OE_O & ~ext[1];
  assign GP_D_I = ~GP_D_OE_O & ~ext[2];
  assign GP_E_I = ~GP_E_OE_O & ~ext[3];
  spg_top #(.BLANK_CYC(8)) dut (
    .MCLK_I, .NRST_I, .CE_I, .BAUD_DIV_I, .PARITY_MODE_I, .CHAR_8BIT_I, .GP_B_DSR_EN_I,
    .GP_C_DTR_EN_I, .GP_D_MODE_I, .GP_E_RTS_EN_I, .GP_OUT_I, .GP_IN_O, .DTR_ASSERT_I,
    .DSR_ACTIVE_O, .HALF_DUPLEX_O, .TX_DATA_I, .TX_VALID_I, .TX_READY_O, .RX_ACCEPT_I,
    .RX_DATA_O, .RX_VALID_O, .RX_PARITY_ERR_O, .RX_FRAME_ERR_O, .TX_O, .RX_I, .GP_B_I, .GP_B_O,
    .GP_B_OE_O, .GP_C_I, .GP_C_O, .GP_C_OE_O, .GP_D_I, .GP_D_O, .GP_D_OE_O, .GP_E_I, .GP_E_O,
    .GP_E_OE_O, .LINK_UP_I, .LINK_100M_I, .PKT_RX_I, .STATUS_GREEN_I, .STATUS_RED_I,
    .LINK_SPEED_LED_O, .LINK_ACT_LED_O, .STATUS_LED_A_O, .STATUS_LED_B_O,
    .BOOT_MODE_SELECT_I, .APP_RUN_O, .UPGRADE_MODE_O, .PROG_MODE_O
  );
  spg_host_model #(.DIV(DIV)) host (.clk_i(MCLK_I), .dev_tx_i(TX_O), .dev_rx_o(RX_I));
  initial begin
    forever #10 MCLK_I = ~MCLK_I;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge MCLK_I);
  endtask
  task automatic tick(inout int t);
    @(negedge MCLK_I);
    t++;
    if (t > 600) begin
      n_fail++;
      test_done();
    end
  endtask
  // Holds the request until the device is ready
  task automatic send(input logic [7:0] d);
    int t;
    t = 0;
    @(negedge MCLK_I);
    TX_DATA_I = d;
    TX_VALID_I = 1'b1;
    while (TX_READY_O !== 1'b1) tick(t);
    @(negedge MCLK_I);
    TX_VALID_I = 1'b0;
  endtask
  task automatic wait_rx;
    int t;
    t = 0;
    while (RX_VALID_O !== 1'b1) tick(t);
  endtask
  // Expected frame: start, data LSB first, parity, stop
  function automatic logic [10:0] mkf(input logic [7:0] d, input logic b8, input logic [2:0] p);
    logic [10:0] f;
    int nd;
    nd = b8 ? 8 : 7;
    f = 11'h0;
    for (int i = 0; i < nd; i++) f[1 + i] = d[i];
    case (p)
      3'h1: f[1 + nd] = ^f;
      3'h2: f[1 + nd] = ~^f;
      3'h3: f[1 + nd] = 1'b1;
      default: f[1 + nd] = 1'b0;
    endcase
    f[nd + ((p != 3'h0) ? 2 : 1)] = 1'b1;
    return f;
  endfunction
  task automatic trx(input logic b8, input logic [2:0] p, input logic [10:0] flip);
    logic [7:0] d;
    logic [10:0] f, g;
    bit ok;
    int n;
    d = 8'hA6 ^ {p, p, p[1:0]};
    f = mkf(d, b8, p);
    n = (b8 ? 10 : 9) + ((p != 3'h0) ? 1 : 0);
    CHAR_8BIT_I = b8;
    PARITY_MODE_I = p;
    fork
      send(d);
      host.get_frame(n, g, ok);
    join
    chk(16'(ok), 16'h1);
    chk(16'(g), 16'(f));
    fork
      host.put_frame(f ^ flip, n);
      wait_rx();
    join
    chk(16'(RX_DATA_O), 16'(b8 ? d : {1'b0, d[6:0]}));
    chk(16'({RX_PARITY_ERR_O, RX_FRAME_ERR_O}), 16'({flip != 11'h0, 1'b0}));
  endtask
  task automatic do_reset(input logic boot_hi);
    BOOT_MODE_SELECT_I = boot_hi;
    NRST_I = 1'b0;
    step(6);
    NRST_I = 1'b1;
    step(3);
  endtask
  initial begin
    logic [10:0] g;
    bit ok;
    do_reset(1'b1);
    chk(16'({APP_RUN_O, UPGRADE_MODE_O, PROG_MODE_O}), 16'h4);
    for (int p = 0; p < 5; p++) begin
      trx(1'b0, 3'(p), 11'h0);
      trx(1'b1, 3'(p), 11'h0);
    end
    trx(1'b1, 3'h1, 11'h200);
    chk(16'({GP_IN_O, GP_B_OE_O, GP_C_OE_O, GP_D_OE_O, GP_E_OE_O}), 16'hF0);
    CE_I = 1'b0;
    GP_OUT_I = 4'hD;
    step(3);
    chk(16'({GP_IN_O, GP_C_OE_O}), 16'h1E);
    CE_I = 1'b1;
    step(3);
    chk(16'({GP_IN_O, GP_B_OE_O, GP_C_OE_O, GP_D_OE_O, GP_E_OE_O}), 16'hD4);
    chk(16'({GP_B_O, GP_C_O, GP_D_O, GP_E_O}), 16'h0);
    GP_OUT_I = 4'hF;
    ext = 4'h1;
    step(3);
    chk(16'({GP_IN_O, GP_B_OE_O}), 16'h1C);
    GP_B_DSR_EN_I = 1'b1;
    GP_OUT_I = 4'hE;
    step(3);
    chk(16'({DSR_ACTIVE_O, GP_B_OE_O}), 16'h2);
    GP_C_DTR_EN_I = 1'b1;
    DTR_ASSERT_I = 1'b1;
    ext = 4'h0;
    step(3);
    chk(16'({DSR_ACTIVE_O, GP_C_OE_O}), 16'h1);
    DTR_ASSERT_I = 1'b0;
    GP_D_MODE_I = 2'h1;
    step(3);
    chk(16'({GP_C_OE_O, TX_READY_O, HALF_DUPLEX_O}), 16'h0);
    fork
      send(8'h5A);
      begin
        step(10);
        chk(16'(TX_O), 16'h1);
        ext = 4'h4;
      end
      host.get_frame(11, g, ok);
    join
    chk(16'(ok), 16'h1);
    chk(16'(g), 16'(mkf(8'h5A, 1'b1, 3'h1)));
    GP_D_MODE_I = 2'h2;
    GP_E_RTS_EN_I = 1'b1;
    ext = 4'h0;
    step(100);
    chk(16'({HALF_DUPLEX_O, GP_E_OE_O}), 16'h3);
    fork
      send(8'h3C);
      begin
        step(20);
        chk(16'(GP_E_OE_O), 16'h0);
      end
    join
    step(120);
    chk(16'(GP_E_OE_O), 16'h1);
    GP_D_MODE_I = 2'h0;
    RX_ACCEPT_I = 1'b1;
    step(3);
    chk(16'({HALF_DUPLEX_O, GP_E_OE_O}), 16'h1);
    RX_ACCEPT_I = 1'b0;
    LINK_UP_I = 1'b1;
    LINK_100M_I = 1'b1;
    STATUS_GREEN_I = 1'b1;
    step(3);
    chk(16'({GP_E_OE_O, LINK_SPEED_LED_O, LINK_ACT_LED_O}), 16'h3);
    chk(16'({STATUS_LED_A_O, STATUS_LED_B_O}), 16'h2);
    LINK_100M_I = 1'b0;
    STATUS_GREEN_I = 1'b0;
    STATUS_RED_I = 1'b1;
    PKT_RX_I = 1'b1;
    step(1);
    PKT_RX_I = 1'b0;
    step(3);
    chk(16'({LINK_SPEED_LED_O, LINK_ACT_LED_O, STATUS_LED_A_O, STATUS_LED_B_O}), 16'h1);
    step(4);
    chk(16'(LINK_ACT_LED_O), 16'h0);
    step(1);
    chk(16'(LINK_ACT_LED_O), 16'h1);
    BOOT_MODE_SELECT_I = 1'b0;
    step(3);
    chk(16'({APP_RUN_O, UPGRADE_MODE_O, PROG_MODE_O}), 16'h1);
    NRST_I = 1'b0;
    step(1);
    chk(16'({TX_O, GP_C_OE_O, GP_E_OE_O}), 16'h4);
    chk(16'({LINK_ACT_LED_O, STATUS_LED_B_O, PROG_MODE_O}), 16'h0);
    do_reset(1'b0);
    chk(16'({APP_RUN_O, UPGRADE_MODE_O, PROG_MODE_O}), 16'h2);
    test_done();
  end
endmodule
